// *** rtl/ipd_pkg.sv ***
package ipd_pkg;

   // ==========================================================
   // Register indices (byte address is four times the index)
   // ==========================================================
   localparam logic [7:0] PWR_CTL_IDX    = 8'h87;
   localparam logic [7:0] SCFG_IDX       = 8'hBF;
   localparam logic [7:0] STAT_IDX       = 8'h01;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int         PC_IDLE_BIT    = 0;
   localparam int         PC_PWRDN_BIT   = 1;
   localparam int         PC_GF_LO_BIT   = 2;
   localparam int         PC_GF_HI_BIT   = 3;
   localparam int         PC_BAUD_BIT    = 7;
   localparam int         SC_WAKE_EN_BIT = 4;
   localparam int         ST_WAKE_A_BIT  = 0;
   localparam int         ST_WAKE_B_BIT  = 1;
   localparam int         ST_WAKE_R_BIT  = 2;

   // ==========================================================
   // Reset values and masks
   // ==========================================================
   localparam logic [7:0] PWR_CTL_RST    = 8'h00;
   // Idle pin levels {reset, pin b, pin a}: reset low, interrupt pins high
   localparam logic [2:0] PIN_IDLE       = 3'h3;
   localparam logic [7:0] SCFG_RST       = 8'h02;
   localparam logic [7:0] SCFG_WMASK     = 8'h13;
   localparam logic [2:0] HSIZE_WORD     = 3'h2;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int         CLK_FREQ_MHZ   = 125;
   localparam int         SETTLE_NS      = 2000;
   localparam int         SETTLE_CYC     = (SETTLE_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam logic [7:0] SETTLE_LAST    = 8'(SETTLE_CYC - 1);

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [3:0] {
      ST_RUN    = 4'b0001,
      ST_IDLE   = 4'b0010,
      ST_PDOWN  = 4'b0100,
      ST_SETTLE = 4'b1000
   } ipd_state_e;

   typedef struct packed {
      logic hold;
      logic ale;
      logic pss;
      logic port0_float;
      logic port2_addr;
   } ipd_pins_s;

endpackage : ipd_pkg

// *** rtl/ipd_settle.sv ***
`timescale 1ns/1ps

// Counts the restarted oscillator through its settling time
module ipd_settle
   import ipd_pkg::*;
(
   // Clock and reset
   input  wire logic mclk,
   input  wire logic resetn,
   input  wire logic clk_en,
   // Control
   input  wire logic run,
   output wire logic done
);

   logic [7:0] cnt_ff;
   logic [7:0] nxt_cnt;

   // Restarts from zero whenever a new settle window opens
   assign nxt_cnt = (run && cnt_ff != SETTLE_LAST) ? cnt_ff + 8'h01 : 8'h00;
   assign done    = run && (cnt_ff == SETTLE_LAST);

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         cnt_ff <= 8'h00;
      else if (clk_en)
         cnt_ff <= nxt_cnt;
   end

endmodule : ipd_settle

// *** rtl/ipd_top.sv ***
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps

module ipd_top
   import ipd_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic        clk_en,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output wire logic        hreadyout,
   output wire logic [31:0] hrdata,
   output wire logic        hresp,
   // Pins
   input  wire logic        ext_irq_pin_a,
   input  wire logic        ext_irq_pin_b,
   input  wire logic        reset_pin,
   // Interrupt controller and core
   input  wire logic        global_irq_enable,
   input  wire logic        ext_irq_a_enable,
   input  wire logic        ext_irq_b_enable,
   input  wire logic        irq_pending,
   input  wire logic        ext_prog_mem,
   // Clock and reset control
   output wire logic        cpu_clk_en,
   output wire logic        periph_clk_en,
   output wire logic        osc_en,
   output wire logic        core_reset,
   output wire logic        wake_irq_a,
   output wire logic        wake_irq_b,
   // Pin state and config
   output wire logic        baud_double_bit,
   output wire ipd_pins_s   pin_ctl
);

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   logic [2:0] sync1_ff;
   logic [2:0] sync2_ff;
   wire  [2:0] pins_raw = {reset_pin, ext_irq_pin_b, ext_irq_pin_a};

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         // Idle levels, so no false wake or core reset follows reset
         sync1_ff <= PIN_IDLE;
         sync2_ff <= PIN_IDLE;
      end
      else if (clk_en)
      begin
         sync1_ff <= pins_raw;
         sync2_ff <= sync1_ff;
      end
   end

   wire pin_a_low = !sync2_ff[0];
   wire pin_b_low = !sync2_ff[1];
   wire rst_pin_s = sync2_ff[2];

   // ==========================================================
   // Bus decode
   // ==========================================================
   logic       wr_ph_ff;
   logic       rd_ph_ff;
   logic [7:0] idx_ff;
   logic [31:0] hrdata_ff;

   wire       addr_take = hsel && htrans[1] && hready && clk_en && (hsize == HSIZE_WORD);
   wire       mapped    = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
   wire [7:0] addr_idx  = haddr[9:2];
   wire       wr_now    = wr_ph_ff && clk_en;
   wire       wr_ctl    = wr_now && (idx_ff == PWR_CTL_IDX);
   wire       wr_scfg   = wr_now && (idx_ff == SCFG_IDX);
   wire       wr_stat   = wr_now && (idx_ff == STAT_IDX);
   wire [7:0] wdat      = hwdata[7:0];

   // Stalls the bus while state is frozen, so no transfer is half taken
   assign hreadyout = clk_en;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_ff;

   // ==========================================================
   // Registers and mode state
   // ==========================================================
   ipd_state_e state_ff;
   ipd_state_e nxt_state;
   logic       baud_ff, gf_hi_ff, gf_lo_ff;
   logic       nxt_baud, nxt_gf_hi, nxt_gf_lo;
   logic [7:0] scfg_ff;
   logic [7:0] nxt_scfg;
   logic [2:0] wflag_ff;
   logic [2:0] nxt_wflag;
   logic [1:0] src_ff;
   logic [1:0] nxt_src;
   logic       wake_a_ff, wake_b_ff;
   ipd_pins_s  pin_ff;
   ipd_pins_s  nxt_pin;
   logic [31:0] nxt_rdata;
   wire        settle_done;

   wire st_run    = (state_ff == ST_RUN);
   wire st_idle   = (state_ff == ST_IDLE);
   wire st_pdown  = (state_ff == ST_PDOWN);
   wire st_settle = (state_ff == ST_SETTLE);

   wire wake_en   = scfg_ff[SC_WAKE_EN_BIT] && global_irq_enable;
   wire wake_a    = wake_en && ext_irq_a_enable && pin_a_low;
   wire wake_b    = wake_en && ext_irq_b_enable && pin_b_low;
   wire go_pd     = st_run && wr_ctl && wdat[PC_PWRDN_BIT];
   wire go_idle   = st_run && wr_ctl && wdat[PC_IDLE_BIT];
   wire sw_wr_ok  = st_run && !rst_pin_s;
   wire sw_ctl_wr = sw_wr_ok && wr_ctl;

   always_comb
   begin
      nxt_state = state_ff;
      if (rst_pin_s)
         nxt_state = ST_RUN;
      else
         unique case (state_ff)
            ST_RUN:
               if (go_pd)
                  nxt_state = ST_PDOWN;
               else if (go_idle)
                  nxt_state = ST_IDLE;
            ST_IDLE:
               if (irq_pending)
                  nxt_state = ST_RUN;
            ST_PDOWN:
               if (wake_a || wake_b)
                  nxt_state = ST_SETTLE;
            ST_SETTLE:
               if (settle_done)
                  nxt_state = ST_RUN;
            default:
               nxt_state = ST_RUN;
         endcase
   end

   // Plain storage flags; the internal reset from the pin clears them too
   assign nxt_gf_hi = rst_pin_s ? 1'b0 : sw_ctl_wr ? wdat[PC_GF_HI_BIT] : gf_hi_ff;
   assign nxt_gf_lo = rst_pin_s ? 1'b0 : sw_ctl_wr ? wdat[PC_GF_LO_BIT] : gf_lo_ff;
   assign nxt_baud  = rst_pin_s ? 1'b0 : sw_ctl_wr ? wdat[PC_BAUD_BIT] : baud_ff;
   assign nxt_scfg  = rst_pin_s ? SCFG_RST :
                      (sw_wr_ok && wr_scfg) ? (wdat & SCFG_WMASK) : scfg_ff;

   // Pin source remembered while the oscillator settles
   assign nxt_src = (st_pdown && !rst_pin_s && (wake_a || wake_b)) ? {wake_b, wake_a} : src_ff;

   wire done_a = st_settle && settle_done && !rst_pin_s && src_ff[0];
   wire done_b = st_settle && settle_done && !rst_pin_s && src_ff[1];
   wire wake_r = st_pdown && rst_pin_s;

   // Wake causes: write one to clear, a new cause in that cycle wins
   wire [2:0] wclr = (sw_wr_ok && wr_stat) ? wdat[2:0] : 3'h0;
   wire [2:0] wset = {wake_r, done_b, done_a};
   assign nxt_wflag = (wflag_ff & ~wclr) | wset;

   // Strobe and port state follow the mode in the same cycle as state_ff
   always_comb
   begin
      nxt_pin             = '0;
      nxt_pin.hold        = (nxt_state == ST_IDLE) || (nxt_state == ST_PDOWN);
      nxt_pin.ale         = (nxt_state == ST_IDLE);
      nxt_pin.pss         = (nxt_state == ST_IDLE);
      nxt_pin.port0_float = nxt_pin.hold && ext_prog_mem;
      nxt_pin.port2_addr  = (nxt_state == ST_IDLE) && ext_prog_mem;
   end

   // Read data reflect a write landing in the same cycle
   wire [7:0] pwr_ctl_rd = {nxt_baud, 3'h0, nxt_gf_hi, nxt_gf_lo, 2'h0};
   wire [7:0] rd_sel     = (addr_idx == PWR_CTL_IDX) ? pwr_ctl_rd :
                        (addr_idx == SCFG_IDX) ? nxt_scfg :
                        (addr_idx == STAT_IDX) ? {5'h0, nxt_wflag} : 8'h00;
   assign nxt_rdata = (addr_take && !hwrite && mapped) ? {24'h0, rd_sel} : 32'h0;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_ff  <= ST_RUN;
         baud_ff   <= PWR_CTL_RST[PC_BAUD_BIT];
         gf_hi_ff  <= PWR_CTL_RST[PC_GF_HI_BIT];
         gf_lo_ff  <= PWR_CTL_RST[PC_GF_LO_BIT];
         scfg_ff   <= SCFG_RST;
         wflag_ff  <= 3'h0;
         src_ff    <= 2'h0;
         wake_a_ff <= 1'b0;
         wake_b_ff <= 1'b0;
         pin_ff    <= '0;
         wr_ph_ff  <= 1'b0;
         rd_ph_ff  <= 1'b0;
         idx_ff    <= 8'h00;
         hrdata_ff <= 32'h0;
      end
      else if (clk_en)
      begin
         state_ff  <= nxt_state;
         baud_ff   <= nxt_baud;
         gf_hi_ff  <= nxt_gf_hi;
         gf_lo_ff  <= nxt_gf_lo;
         scfg_ff   <= nxt_scfg;
         wflag_ff  <= nxt_wflag;
         src_ff    <= nxt_src;
         wake_a_ff <= done_a;
         wake_b_ff <= done_b;
         pin_ff    <= nxt_pin;
         wr_ph_ff  <= addr_take && hwrite && mapped;
         rd_ph_ff  <= addr_take && !hwrite && mapped && (addr_idx == PWR_CTL_IDX);
         idx_ff    <= addr_idx;
         hrdata_ff <= nxt_rdata;
      end
   end

   ipd_settle u_settle (
      .mclk   (mclk),
      .resetn (resetn),
      .clk_en (clk_en),
      .run    (st_settle),
      .done   (settle_done)
   );

   // ==========================================================
   // Outputs
   // ==========================================================
   assign cpu_clk_en      = st_run;
   assign periph_clk_en   = st_run || st_idle;
   assign osc_en          = !st_pdown;
   assign core_reset      = rst_pin_s;
   assign wake_irq_a      = wake_a_ff;
   assign wake_irq_b      = wake_b_ff;
   assign baud_double_bit = baud_ff;
   assign pin_ctl         = pin_ff;

   // ==========================================================
   // Assertions
   // ==========================================================
   localparam int SETTLE_MAX = 260;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   a_ctl_mode_read: assert property (rd_ph_ff |-> hrdata[1:0] == 2'h0)
      else $error("Mode bits read back as nonzero");
   a_idle_bit_read: assert property (rd_ph_ff && st_idle |-> hrdata[PC_IDLE_BIT] == 1'b0)
      else $error("Idle bit read back as nonzero");
   a_flag_store: assert property (go_idle && !rst_pin_s |=>
      {gf_hi_ff, gf_lo_ff} == $past(wdat[3:2]))
      else $error("General flags did not store written value");
   a_idle_clk_gate: assert property (clk_en && go_idle && !go_pd && !rst_pin_s |=>
      !cpu_clk_en && periph_clk_en)
      else $error("Idle entry did not gate only the core clock");
   a_idle_wake: assert property (clk_en && st_idle && irq_pending |=> cpu_clk_en)
      else $error("Enabled interrupt did not end idle");
   a_reset_wake: assert property (clk_en && (st_idle || st_pdown) && rst_pin_s |=>
      st_run && core_reset)
      else $error("Reset pin did not end low-power mode");
   a_pd_osc_stop: assert property (clk_en && go_pd && !rst_pin_s |=> !osc_en && st_pdown)
      else $error("Power-down did not stop oscillator");
   a_pd_retain: assert property (st_pdown && !rst_pin_s |=>
      $stable(scfg_ff) && $stable({baud_ff, gf_hi_ff, gf_lo_ff}))
      else $error("Registers changed during power-down");
   a_wake_gated: assert property (clk_en && st_pdown && !scfg_ff[SC_WAKE_EN_BIT] |=>
      !st_settle)
      else $error("Pin wake without wake enable");
   a_settle_min: assert property ($rose(st_settle) |-> !cpu_clk_en [*8])
      else $error("Core ran before settle time");
   a_settle_max: assert property ($rose(st_settle) |-> ##[1:SETTLE_MAX] !st_settle)
      else $error("Settle window never ended");
   a_wake_vector: assert property (done_a && clk_en |=> wake_irq_a && st_run)
      else $error("Pin wake did not raise its interrupt");
   a_strobe_level: assert property (st_idle |-> pin_ctl.ale && pin_ctl.pss)
      else $error("Strobes not high in idle");
   a_strobe_pd: assert property (st_pdown |-> !pin_ctl.ale && !pin_ctl.pss &&
      !pin_ctl.port2_addr)
      else $error("Strobes or port 2 wrong in power-down");
   a_pd_priority: assert property (clk_en && go_pd && go_idle && !rst_pin_s |=> st_pdown)
      else $error("Power-down did not win over idle");

   c_idle_cycle: cover property (st_idle ##1 st_run);
   c_pin_wake: cover property (st_settle ##1 st_run);
   c_reset_wake: cover property (st_pdown && rst_pin_s);
   c_both_bits: cover property (go_pd && go_idle);

endmodule : ipd_top

// *** testbench/ipd_core_model.sv ***
`timescale 1ns/1ps

// Core and interrupt controller as seen from the power unit
module ipd_core_model
#(
   parameter logic [15:0] VEC_A = 16'h0003,
   parameter logic [15:0] VEC_B = 16'h0013
)
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        resetn,
   // From the power unit
   input  wire logic        cpu_clk_en,
   input  wire logic        core_reset,
   input  wire logic        wake_irq_a,
   input  wire logic        wake_irq_b,
   // Bench control
   input  wire logic        irq_req,
   input  wire logic [7:0]  irq_delay,
   // To power unit and bench
   output logic             irq_pending,
   output logic [15:0]      entry
);
   logic [8:0] cnt_ff;

   // ==========================================================
   // One pending interrupt per request, after a chosen delay
   // ==========================================================
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_ff      <= 9'h000;
         irq_pending <= 1'b0;
         entry       <= 16'h0000;
      end
      else
      begin
         cnt_ff <= !irq_req ? 9'h000 : (cnt_ff > {1'b0, irq_delay}) ? cnt_ff : cnt_ff + 9'h001;
         if (irq_req && cnt_ff == {1'b0, irq_delay})
            irq_pending <= 1'b1;
         else if (cpu_clk_en)
            irq_pending <= 1'b0;
         // Entry point the core takes when it starts running again
         if (core_reset)
            entry <= 16'h0000;
         else if (wake_irq_a)
            entry <= VEC_A;
         else if (wake_irq_b)
            entry <= VEC_B;
      end
   end
endmodule : ipd_core_model

// *** testbench/ipd_top_tb.sv ***
`timescale 1ns/1ps

module ipd_top_tb;
   import ipd_pkg::*;
   logic        mclk, resetn, clk_en, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, q, rs, m_ctl;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        pin_a, pin_b, reset_pin, g_en, a_en, b_en, ext_mem, irq_req, irq_pending;
   logic        cpu_clk_en, periph_clk_en, osc_en, core_reset, wake_a, wake_b, baud;
   logic [7:0]  irq_delay;
   logic [15:0] entry;
   ipd_pins_s   pin_ctl;
   int          num_errors, checked, n;

   assign hready = hreadyout;

   ipd_top DUT (.mclk(mclk), .resetn(resetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ext_irq_pin_a(pin_a),
      .ext_irq_pin_b(pin_b), .reset_pin(reset_pin), .global_irq_enable(g_en),
      .ext_irq_a_enable(a_en), .ext_irq_b_enable(b_en), .irq_pending(irq_pending),
      .ext_prog_mem(ext_mem), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
      .osc_en(osc_en), .core_reset(core_reset), .wake_irq_a(wake_a), .wake_irq_b(wake_b),
      .baud_double_bit(baud), .pin_ctl(pin_ctl));

   ipd_core_model core_model (.mclk(mclk), .resetn(resetn), .cpu_clk_en(cpu_clk_en),
      .core_reset(core_reset), .wake_irq_a(wake_a), .wake_irq_b(wake_b), .irq_req(irq_req),
      .irq_delay(irq_delay), .irq_pending(irq_pending), .entry(entry));

   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs

   task chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e)
      begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk

   task close_out;
      if (num_errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out

   // Single word transfer; read data lands in q at the end of the data phase
   task ahb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
      @(posedge mclk);
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, idx} << 2;
      htrans <= 2'b10;
      hwrite <= wr;
      hsize  <= HSIZE_WORD;
      n = 0;
      do begin @(posedge mclk); n++; end while (hready !== 1'b1 && n < 50);
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= d;
      do begin @(posedge mclk); n++; end while (hready !== 1'b1 && n < 100);
      // A bus that never answers counts as a mismatch
      if (hready !== 1'b1)
         num_errors++;
      q = hrdata;
   endtask : ahb

   task rd(input logic [7:0] idx, input logic [31:0] e);
      ahb(1'b0, idx, 32'h0000_0000);
      chk(q, e);
      chk(hresp, 1'b0);
   endtask : rd

   // Mode 0 run, 1 idle, 2 power-down
   task chk_mode(input int md);
      chk(pin_ctl, md == 0 ? 5'h00 : md == 1 ? {3'b111, ext_mem, ext_mem} :
          {3'b100, ext_mem, 1'b0});
      chk(cpu_clk_en, md == 0);
      chk(periph_clk_en, md != 2);
      chk(osc_en, md != 2);
   endtask : chk_mode

   task wait_run(input int lim);
      n = 0;
      while (cpu_clk_en !== 1'b1 && n < lim) begin @(posedge mclk); n++; end
   endtask : wait_run

   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   initial
   begin
      #(8 * 20000);
      num_errors++;
      close_out;
   end

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial
   begin
      {resetn, hsel, hwrite, htrans, hsize, haddr, hwdata, irq_req, irq_delay} = '0;
      // Interrupt pins idle high, reset pin low, every enable on
      {clk_en, pin_a, pin_b, reset_pin, g_en, a_en, b_en, ext_mem} = 8'hEE;
      num_errors = 0;
      checked = 0;
      rs = 32'h0001_5EAB;
      m_ctl = 32'h0000_0000;
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      #1 chk_mode(0);
      rd(PWR_CTL_IDX, PWR_CTL_RST);
      rd(SCFG_IDX, SCFG_RST);
      rd(8'h10, 32'h0000_0000);
      for (int i = 0; i < 6; i++)
      begin
         rs = xs(rs);
         ext_mem <= rs[8];
         m_ctl = rs & 32'h0000_008C;
         ahb(1'b1, PWR_CTL_IDX, m_ctl);
         #1 chk_mode(0);
         chk(baud, m_ctl[7]);
         rd(PWR_CTL_IDX, m_ctl);
      end
      ahb(1'b1, SCFG_IDX, 32'h0000_0012);
      rd(SCFG_IDX, 32'h0000_0012 & SCFG_WMASK);
      for (int p = 0; p < 2; p++)
      begin
         ahb(1'b1, PWR_CTL_IDX, m_ctl | 32'h0000_0002);
         #1 chk_mode(2);
         @(posedge mclk);
         g_en  <= 1'b0;
         pin_a <= (p != 0);
         pin_b <= (p == 0);
         repeat (20) @(posedge mclk);
         #1 chk_mode(2);
         @(posedge mclk);
         g_en <= 1'b1;
         wait_run(400);
         chk(n >= SETTLE_CYC && n <= SETTLE_CYC + 6, 1'b1);
         chk({wake_b, wake_a}, p == 0 ? 2'b01 : 2'b10);
         pin_a <= 1'b1;
         pin_b <= 1'b1;
         repeat (2) @(posedge mclk);
         #1 chk(entry, p == 0 ? 16'h0003 : 16'h0013);
         rd(PWR_CTL_IDX, m_ctl);
         rd(STAT_IDX, 32'h0000_0001 << (p == 0 ? ST_WAKE_A_BIT : ST_WAKE_B_BIT));
         ahb(1'b1, STAT_IDX, 32'h0000_0007);
      end
      for (int k = 0; k < 2; k++)
      begin
         rs = xs(rs);
         irq_delay <= k ? 8'(rs[4:0]) + 8'h3C : 8'h00;
         ahb(1'b1, PWR_CTL_IDX, m_ctl | 32'h0000_0001);
         #1 chk_mode(1);
         // A write while idle must not land; reads still answer
         if (k)
         begin
            ahb(1'b1, PWR_CTL_IDX, 32'h0000_0000);
            rd(PWR_CTL_IDX, m_ctl);
         end
         #1 chk_mode(1);
         @(posedge mclk);
         irq_req <= 1'b1;
         wait_run(200);
         irq_req <= 1'b0;
         #1 chk_mode(0);
         chk(entry, 16'h0013);
         rd(PWR_CTL_IDX, m_ctl);
      end
      for (int k = 0; k < 2; k++)
      begin
         // With the wake enable off a low pin must not end power-down
         if (k == 0)
            ahb(1'b1, SCFG_IDX, 32'h0000_0002);
         ahb(1'b1, PWR_CTL_IDX, m_ctl | (k ? 32'h0000_0001 : 32'h0000_0003));
         #1 chk_mode(k ? 1 : 2);
         @(posedge mclk);
         pin_a <= (k != 0);
         repeat (8) @(posedge mclk);
         #1 chk_mode(k ? 1 : 2);
         @(posedge mclk);
         reset_pin <= 1'b1;
         n = 0;
         while (core_reset !== 1'b1 && n < 10) begin @(posedge mclk); n++; end
         chk(core_reset, 1'b1);
         // Held well past the sync stages; the real hold is scaled down here
         repeat (10) @(posedge mclk);
         reset_pin <= 1'b0;
         pin_a     <= 1'b1;
         m_ctl = 32'h0000_0000;
         repeat (4) @(posedge mclk);
         #1 chk_mode(0);
         chk(entry, 16'h0000);
         rd(PWR_CTL_IDX, m_ctl);
         rd(SCFG_IDX, SCFG_RST);
         rd(STAT_IDX, k ? 32'h0000_0000 : 32'h0000_0001 << ST_WAKE_R_BIT);
         ahb(1'b1, STAT_IDX, 32'h0000_0007);
      end
      // A frozen block stalls the bus and keeps its registers
      @(posedge mclk);
      clk_en <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(hreadyout, 1'b0);
      chk(cpu_clk_en, 1'b1);
      clk_en <= 1'b1;
      rd(SCFG_IDX, SCFG_RST);
      close_out;
   end
endmodule : ipd_top_tb
